// ===== logic/frg_div.sv
// Iterative restoring divider used to turn a ramp time into a per-tick increment.
`timescale 1ns/1ps
module frg_div #(
    parameter int unsigned NUM_W = 32,
    parameter int unsigned DEN_W = 24
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Request
    input  wire logic             start_i,
    input  wire logic [NUM_W-1:0] num_i,
    input  wire logic [DEN_W-1:0] den_i,
    // Answer
    output logic                  busy_o,
    output logic                  done_o,
    output logic [NUM_W-1:0]      quo_o
);
    localparam int unsigned CNT_W = $clog2(NUM_W + 1);

    logic [DEN_W:0]   rem_q;
    logic [NUM_W-1:0] num_q;
    logic [DEN_W-1:0] den_q;
    logic [CNT_W-1:0] cnt_q;
    logic [DEN_W:0]   rem_sh;

    assign rem_sh = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rem_q  <= '0;
            num_q  <= '0;
            den_q  <= '0;
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            quo_o  <= '0;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && start_i) begin
                rem_q  <= '0;
                num_q  <= num_i;
                den_q  <= den_i;
                cnt_q  <= CNT_W'(NUM_W);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (rem_sh >= {1'b0, den_q}) begin
                    rem_q <= rem_sh - {1'b0, den_q};
                    num_q <= {num_q[NUM_W-2:0], 1'b1};
                end else begin
                    rem_q <= rem_sh;
                    num_q <= {num_q[NUM_W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    // A zero divisor yields all ones, so the ramp jumps at once.
                    quo_o  <= (den_q == '0) ? '1 :
                              ((rem_sh >= {1'b0, den_q}) ? {num_q[NUM_W-2:0], 1'b1}
                                                        : {num_q[NUM_W-2:0], 1'b0});
                end
            end
        end
    end
endmodule : frg_div

// ===== logic/frg_pkg.sv
// Constants shared by the frequency ramp generator and its port checker.
package frg_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TICK_PERIOD_US  = 1000;
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

    localparam int unsigned RAW_W   = 16;
    localparam int unsigned MS_W    = 24;
    localparam int unsigned FRAC_W  = 16;
    localparam int unsigned ACC_W   = RAW_W + FRAC_W;
    localparam int unsigned SEL_W   = 5;
    localparam int unsigned NUM_SETS = 4;

    localparam logic [SEL_W-1:0] SEL_TIME0    = 5'h00;
    localparam logic [SEL_W-1:0] SEL_TIME_END = 5'h07;
    localparam logic [SEL_W-1:0] SEL_FS_TIME  = 5'h08;
    localparam logic [SEL_W-1:0] SEL_UNIT     = 5'h09;
    localparam logic [SEL_W-1:0] SEL_SW_FREQ  = 5'h0a;
    localparam logic [SEL_W-1:0] SEL_RATE     = 5'h0b;
    localparam logic [SEL_W-1:0] SEL_SC0      = 5'h0c;
    localparam logic [SEL_W-1:0] SEL_SC_END   = 5'h0f;
    localparam logic [SEL_W-1:0] SEL_MAX_FREQ = 5'h10;

    localparam logic [RAW_W-1:0] TIME_RAW_MAX    = 16'hea60;
    localparam logic [RAW_W-1:0] TIME_UNIT0_LIM  = 16'h1771;
    localparam logic [RAW_W-1:0] FREQ_RAW_MAX    = 16'h0fa0;
    localparam logic [RAW_W-1:0] SC_RAW_MAX      = 16'h03e8;

    localparam logic [RAW_W-1:0] TIME_DEFAULT    = 16'h0064;
    localparam logic             UNIT_DEFAULT    = 1'b1;
    localparam logic [RAW_W-1:0] FREQ_OFF        = 16'h0000;
    localparam logic [RAW_W-1:0] SC_ACC_END_DEF  = 16'h0014;
    localparam logic [RAW_W-1:0] SC_DEC_STA_DEF  = 16'h0014;
    localparam logic [RAW_W-1:0] SC_DEC_END_DEF  = 16'h0000;

    localparam logic [6:0] MS_PER_TENTH     = 7'h64;
    localparam logic [6:0] MS_PER_HUNDREDTH = 7'h0a;
    localparam logic [3:0] MS_PER_SC_HALF   = 4'h5;

    localparam logic [1:0] SET_AUTO_LOW = 2'h3;
    localparam logic [1:0] SET_DEFAULT  = 2'h0;
endpackage : frg_pkg

// ===== logic/frg_ramp.sv
// Frequency reference ramp generator with fast-stop, time units and S-curve lengthening.
// Summary of operation
// - A normally-open or normally-closed fast-stop input pulse is latched and starts fast-stop.
// - A signalled fault also starts fast-stop deceleration with the fast-stop time.
// - After fast-stop, restart waits for zero speed, cleared request and run re-applied.
// - The fast-stop status output is high for as long as fast-stop is active.
// - Fast-stop time is its own setting, default ten seconds, used only for fast-stop.
// - One time-unit setting scales every accel, decel and fast-stop time.
// - Unit 0 means hundredths of a second, up to six hundred seconds.
// - Unit 1, the default, means tenths of a second, up to six thousand seconds.
// - Writing unit 0 is refused while any time holds 600.1 seconds or more.
// - Switch frequency accepts zero to four hundred hertz; zero disables automatic switching.
// - With rate frequency zero, ramp times span zero to maximum output frequency.
// - With nonzero rate frequency, ramp times span zero to that rate frequency.
// - During rotational auto-tuning the slope uses maximum output frequency only.
// - Four S-curve times, zero to ten seconds, belong to accel and decel start and end; the slope stays linear.
// - S-curves lengthen each ramp by half the sum of its two rounding times.
// - Two select inputs pick one of four accel and decel time pairs.
// - Below the switch frequency set 4 is used; select inputs override this.
`timescale 1ns/1ps
module frg_ramp #(
    parameter int unsigned   TICK_CYCLES  = frg_pkg::TICK_CYCLES,
    parameter logic [15:0]   MAX_FREQ_DEF = 16'h0258,
    parameter logic [15:0]   SC_ACC_STA_DEF = 16'h0000
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        sys_rst_i,
    // Setting writes
    input  wire logic                        cfg_wr_i,
    input  wire logic [frg_pkg::SEL_W-1:0]   cfg_sel_i,
    input  wire logic [frg_pkg::RAW_W-1:0]   cfg_data_i,
    output logic                             cfg_reject_o,
    // Drive input terminals
    input  wire logic                        run_pin_i,
    input  wire logic                        fast_stop_no_pin_i,
    input  wire logic                        fast_stop_nc_n_pin_i,
    input  wire logic [1:0]                  time_sel_pin_i,
    // Internal requests
    input  wire logic                        fault_stop_i,
    input  wire logic                        autotune_i,
    input  wire logic [frg_pkg::RAW_W-1:0]   target_freq_i,
    // Motor control stage and status
    output logic [frg_pkg::RAW_W-1:0]        freq_o,
    output logic                             fast_stop_active_o
);
    localparam int unsigned RAW_W = frg_pkg::RAW_W;
    localparam int unsigned MS_W  = frg_pkg::MS_W;
    localparam int unsigned ACC_W = frg_pkg::ACC_W;
    localparam int unsigned NPIN  = 5;

    typedef enum logic [1:0] {FRG_NORMAL, FRG_FSTOP, FRG_LOCK} frg_state_t;

    frg_state_t       state_q;
    logic [RAW_W-1:0] time_q [8];
    logic [RAW_W-1:0] sc_q [4];
    logic [RAW_W-1:0] fs_time_q, sw_q, rate_q, max_q;
    logic             unit_q;
    logic [NPIN-1:0]  pin_raw, pin_q;
    logic [2:0]       sync_q [NPIN];
    logic             fs_req_q, run_off_seen_q, tick_q;
    logic [31:0]      tick_cnt_q;
    logic [ACC_W-1:0] acc_q, inc_q, tgt, quo;
    logic             reject, any_long, fs_trig, fs_level, div_busy, div_done, inc_ok;
    logic [1:0]       set_idx;
    logic [RAW_W-1:0] base_raw, sa, sb, ref_freq;
    logic [MS_W-1:0]  total_ms;
    logic [MS_W-1:0]  den_q, inc_den_q;
    logic [RAW_W-1:0] ref_q, inc_ref_q;

    assign pin_raw = {time_sel_pin_i, fast_stop_nc_n_pin_i, fast_stop_no_pin_i, run_pin_i};

    // Each pin passes three flops; a change is taken once the last two agree.
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                sync_q[i] <= (i == 2) ? 3'h7 : 3'h0;
                pin_q[i]  <= (i == 2) ? 1'b1 : 1'b0;
            end else begin
                sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
                if (sync_q[i][1] == sync_q[i][2]) begin
                    pin_q[i] <= sync_q[i][2];
                end
            end
        end
    end

    always_comb begin
        any_long = (fs_time_q >= frg_pkg::TIME_UNIT0_LIM);
        for (int k = 0; k < 8; k++) begin
            if (time_q[k] >= frg_pkg::TIME_UNIT0_LIM) begin
                any_long = 1'b1;
            end
        end
    end

    always_comb begin
        reject = 1'b0;
        if (cfg_sel_i <= frg_pkg::SEL_TIME_END || cfg_sel_i == frg_pkg::SEL_FS_TIME) begin
            reject = (cfg_data_i > frg_pkg::TIME_RAW_MAX);
        end else if (cfg_sel_i == frg_pkg::SEL_UNIT) begin
            reject = (cfg_data_i > RAW_W'(1)) || (cfg_data_i == '0 && unit_q && any_long);
        end else if (cfg_sel_i == frg_pkg::SEL_SW_FREQ || cfg_sel_i == frg_pkg::SEL_RATE
                     || cfg_sel_i == frg_pkg::SEL_MAX_FREQ) begin
            reject = (cfg_data_i > frg_pkg::FREQ_RAW_MAX);
        end else if (cfg_sel_i >= frg_pkg::SEL_SC0 && cfg_sel_i <= frg_pkg::SEL_SC_END) begin
            reject = (cfg_data_i > frg_pkg::SC_RAW_MAX);
        end else begin
            reject = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < 8; k++) begin
                time_q[k] <= frg_pkg::TIME_DEFAULT;
            end
            fs_time_q    <= frg_pkg::TIME_DEFAULT;
            unit_q       <= frg_pkg::UNIT_DEFAULT;
            sw_q         <= frg_pkg::FREQ_OFF;
            rate_q       <= frg_pkg::FREQ_OFF;
            max_q        <= MAX_FREQ_DEF;
            sc_q[0]      <= SC_ACC_STA_DEF;
            sc_q[1]      <= frg_pkg::SC_ACC_END_DEF;
            sc_q[2]      <= frg_pkg::SC_DEC_STA_DEF;
            sc_q[3]      <= frg_pkg::SC_DEC_END_DEF;
            cfg_reject_o <= 1'b0;
        end else begin
            cfg_reject_o <= cfg_wr_i && reject;
            if (cfg_wr_i && !reject) begin
                if (cfg_sel_i <= frg_pkg::SEL_TIME_END) begin
                    time_q[cfg_sel_i[2:0]] <= cfg_data_i;
                end else if (cfg_sel_i == frg_pkg::SEL_FS_TIME) begin
                    fs_time_q <= cfg_data_i;
                end else if (cfg_sel_i == frg_pkg::SEL_UNIT) begin
                    unit_q <= cfg_data_i[0];
                end else if (cfg_sel_i == frg_pkg::SEL_SW_FREQ) begin
                    sw_q <= cfg_data_i;
                end else if (cfg_sel_i == frg_pkg::SEL_RATE) begin
                    rate_q <= cfg_data_i;
                end else if (cfg_sel_i == frg_pkg::SEL_MAX_FREQ) begin
                    max_q <= cfg_data_i;
                end else begin
                    sc_q[cfg_sel_i[1:0]] <= cfg_data_i;
                end
            end
        end
    end

    assign fs_level = pin_q[1] || !pin_q[2] || fault_stop_i;
    assign fs_trig  = fs_level && state_q == FRG_NORMAL;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q        <= FRG_NORMAL;
            fs_req_q       <= 1'b0;
            run_off_seen_q <= 1'b0;
        end else begin
            case (state_q)
                FRG_NORMAL: begin
                    if (fs_trig) begin
                        state_q  <= FRG_FSTOP;
                        fs_req_q <= 1'b1;
                    end
                end
                FRG_FSTOP: begin
                    if (acc_q == '0) begin
                        state_q        <= FRG_LOCK;
                        run_off_seen_q <= 1'b0;
                    end
                end
                default: begin
                    if (!pin_q[0]) begin
                        run_off_seen_q <= 1'b1;
                    end
                    if (!fs_level && run_off_seen_q && pin_q[0]) begin
                        state_q  <= FRG_NORMAL;
                        fs_req_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fast_stop_active_o <= 1'b0;
        end else begin
            fast_stop_active_o <= fs_req_q || fs_trig;
        end
    end

    always_comb begin
        if (pin_q[4:3] != 2'h0) begin
            set_idx = pin_q[4:3];
        end else if (sw_q != frg_pkg::FREQ_OFF && acc_q[ACC_W-1 -: RAW_W] < sw_q) begin
            set_idx = frg_pkg::SET_AUTO_LOW;
        end else begin
            set_idx = frg_pkg::SET_DEFAULT;
        end
    end

    assign tgt = (state_q == FRG_NORMAL && pin_q[0]) ? {target_freq_i, 16'h0000} : '0;

    always_comb begin
        if (state_q != FRG_NORMAL) begin
            base_raw = fs_time_q;
            sa       = sc_q[2];
            sb       = sc_q[3];
        end else if (tgt > acc_q) begin
            base_raw = time_q[{set_idx, 1'b0}];
            sa       = sc_q[0];
            sb       = sc_q[1];
        end else begin
            base_raw = time_q[{set_idx, 1'b1}];
            sa       = sc_q[2];
            sb       = sc_q[3];
        end
        total_ms = MS_W'(base_raw)
                 * MS_W'(unit_q ? frg_pkg::MS_PER_TENTH : frg_pkg::MS_PER_HUNDREDTH)
                 + (MS_W'(sa) + MS_W'(sb)) * MS_W'(frg_pkg::MS_PER_SC_HALF);
    end

    assign ref_freq = (rate_q != frg_pkg::FREQ_OFF && !autotune_i) ? rate_q : max_q;

    frg_div #(
        .NUM_W (ACC_W),
        .DEN_W (MS_W)
    ) u_div (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (1'b1),
        .num_i     ({ref_freq, 16'h0000}),
        .den_i     (total_ms),
        .busy_o    (div_busy),
        .done_o    (div_done),
        .quo_o     (quo)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            inc_q      <= '0;
            den_q      <= '0;
            ref_q      <= '0;
            inc_den_q  <= '0;
            inc_ref_q  <= '0;
        end else begin
            tick_q     <= (tick_cnt_q == TICK_CYCLES - 1);
            tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? '0 : tick_cnt_q + 1'b1;
            // The divider takes a new operand pair on every edge at which it is idle.
            if (!div_busy) begin
                den_q <= total_ms;
                ref_q <= ref_freq;
            end
            if (div_done && !div_busy) begin
                inc_q     <= quo;
                inc_den_q <= den_q;
                inc_ref_q <= ref_q;
            end
        end
    end

    // A step waits while the increment still belongs to older settings.
    assign inc_ok = (inc_den_q == total_ms) && (inc_ref_q == ref_freq);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_q  <= '0;
            freq_o <= '0;
        end else begin
            if (tick_q && inc_ok) begin
                if (tgt > acc_q) begin
                    acc_q <= (tgt - acc_q <= inc_q) ? tgt : acc_q + inc_q;
                end else if (acc_q > tgt) begin
                    acc_q <= (acc_q - tgt <= inc_q) ? tgt : acc_q - inc_q;
                end
            end
            freq_o <= acc_q[ACC_W-1 -: RAW_W];
        end
    end
endmodule : frg_ramp

// ===== sim/frg_ramp_asserts.sv
// Port checker for the frequency ramp generator.
`timescale 1ns/1ps
module frg_ramp_asserts (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    // Setting writes
    input  wire logic                      cfg_wr_i,
    input  wire logic [frg_pkg::SEL_W-1:0] cfg_sel_i,
    input  wire logic [frg_pkg::RAW_W-1:0] cfg_data_i,
    input  wire logic                      cfg_reject_o,
    // Requests and outputs
    input  wire logic                      fault_stop_i,
    input  wire logic [frg_pkg::RAW_W-1:0] target_freq_i,
    input  wire logic [frg_pkg::RAW_W-1:0] freq_o,
    input  wire logic                      fast_stop_active_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_reset_clears: assert property (disable iff (1'b0) sys_rst_i |=>
        freq_o == 16'h0000 && !fast_stop_active_o && !cfg_reject_o)
        else $error("outputs not cleared by reset");
    a_fault_starts: assert property (fault_stop_i |-> ##[1:2] fast_stop_active_o)
        else $error("fault did not start fast stop");
    a_fs_held: assert property (fault_stop_i && fast_stop_active_o |=> fast_stop_active_o)
        else $error("fast stop left while request present");
    a_fs_no_rise: assert property (fast_stop_active_o && $past(fast_stop_active_o)
        |-> freq_o <= $past(freq_o))
        else $error("frequency rose during fast stop");
    a_reject_cause: assert property (cfg_reject_o |-> $past(cfg_wr_i))
        else $error("reject without a write");
    a_swf_refuse: assert property (cfg_wr_i && cfg_sel_i == frg_pkg::SEL_SW_FREQ
        && cfg_data_i > frg_pkg::FREQ_RAW_MAX |=> cfg_reject_o)
        else $error("switch frequency above range accepted");
    a_swf_accept: assert property (cfg_wr_i && cfg_sel_i == frg_pkg::SEL_SW_FREQ
        && cfg_data_i <= frg_pkg::FREQ_RAW_MAX |=> !cfg_reject_o)
        else $error("switch frequency in range refused");
    a_sc_refuse: assert property (cfg_wr_i && cfg_data_i > frg_pkg::SC_RAW_MAX
        && cfg_sel_i inside {[frg_pkg::SEL_SC0:frg_pkg::SEL_SC_END]} |=> cfg_reject_o)
        else $error("s-curve time above range accepted");
    a_no_overshoot: assert property ($past(freq_o) <= target_freq_i
        && $stable(target_freq_i) && $past(target_freq_i, 2) == target_freq_i
        |-> freq_o <= target_freq_i)
        else $error("ramp passed its target");

    c_fault: cover property (fault_stop_i ##1 fast_stop_active_o);
    c_reject: cover property (cfg_reject_o);
    c_top: cover property (freq_o == 16'h0258);
endmodule : frg_ramp_asserts

// ===== sim/frg_ramp_tb.sv
// Self-checking testbench for the frequency ramp generator.
`timescale 1ns/1ps
module frg_ramp_tb;
    localparam int TICK = 80;
    logic        clk_i;
    logic        sys_rst;
    logic        cfg_wr;
    logic [4:0]  cfg_sel;
    logic [15:0] cfg_data;
    logic        fault;
    logic        tune;
    logic [15:0] target;
    logic        run, fs_no, fs_nc_n, rej, act;
    logic [1:0]  tsel;
    logic [15:0] freq;
    int          n_mismatch = 0;
    int          checks = 0;

    frg_terminals i_term (.clk_i(clk_i), .run_o(run), .fs_no_o(fs_no),
        .fs_nc_n_o(fs_nc_n), .sel_o(tsel));
    frg_ramp #(.TICK_CYCLES(TICK)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst),
        .cfg_wr_i(cfg_wr), .cfg_sel_i(cfg_sel), .cfg_data_i(cfg_data),
        .cfg_reject_o(rej), .run_pin_i(run), .fast_stop_no_pin_i(fs_no),
        .fast_stop_nc_n_pin_i(fs_nc_n), .time_sel_pin_i(tsel), .fault_stop_i(fault),
        .autotune_i(tune), .target_freq_i(target), .freq_o(freq),
        .fast_stop_active_o(act));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic [4:0] sel, input logic [15:0] data, input logic r);
        @(negedge clk_i);
        cfg_wr = 1'b1;
        cfg_sel = sel;
        cfg_data = data;
        @(negedge clk_i);
        cfg_wr = 1'b0;
        chk(16'(rej), 16'(r));
    endtask : cfg

    // Waits for the output to reach v; the time taken is held against t ticks.
    task automatic ramp(input logic [15:0] v, input int t);
        int n;
        n = 0;
        while (freq !== v && n < 40000) begin
            @(negedge clk_i);
            n++;
        end
        checks++;
        if (n < TICK * (t - 1) - 10 || n > TICK * (t + 3)) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, n, TICK * t);
        end
        if (n >= 40000) results();
    endtask : ramp

    task automatic t_accel();
        chk(freq, 16'h0000);
        chk(16'(act), 16'h0000);
        cfg(5'h09, 16'h0000, 1'b0);
        cfg(5'h00, 16'h0005, 1'b0);
        target = 16'h0258;
        i_term.set_run(1'b1);
        ramp(16'h0258, 150);
        cfg(5'h01, 16'h0001, 1'b0);
        cfg(5'h0e, 16'h0000, 1'b0);
        i_term.set_run(1'b0);
        ramp(16'h0000, 10);
        cfg(5'h0b, 16'h012c, 1'b0);
        i_term.set_run(1'b1);
        ramp(16'h0258, 300);
        tune = 1'b1;
        i_term.set_run(1'b0);
        ramp(16'h0000, 10);
        tune = 1'b0;
        cfg(5'h0b, 16'h0000, 1'b0);
        $display("accel and rate test done");
    endtask : t_accel

    task automatic t_sets();
        cfg(5'h0d, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cfg(5'(2 * i), 16'(1 << i), 1'b0);
            cfg(5'(2 * i + 1), 16'h0001, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            i_term.set_sel(2'(i));
            i_term.set_run(1'b1);
            ramp(16'h0258, 10 << i);
            i_term.set_run(1'b0);
            ramp(16'h0000, 10);
        end
        i_term.set_sel(2'h0);
        cfg(5'h0a, 16'h012c, 1'b0);
        i_term.set_run(1'b1);
        ramp(16'h0258, 45);
        i_term.set_run(1'b0);
        ramp(16'h0000, 10);
        cfg(5'h0a, 16'h0000, 1'b0);
        $display("time set test done");
    endtask : t_sets

    task automatic t_fstop();
        int n;
        cfg(5'h08, 16'h0005, 1'b0);
        for (int s = 0; s < 3; s++) begin
            i_term.set_run(1'b1);
            ramp(16'h0258, 10);
            if (s < 2) begin
                i_term.pulse(s[0]);
            end else begin
                @(negedge clk_i);
                fault = 1'b1;
                repeat (2) @(negedge clk_i);
                fault = 1'b0;
            end
            chk(16'(act), 16'h0001);
            ramp(16'h0000, 50);
            repeat (30) @(negedge clk_i);
            chk(16'(act), 16'h0001);
            chk(freq, 16'h0000);
            i_term.set_run(1'b0);
            repeat (10) @(negedge clk_i);
            chk(16'(act), 16'h0001);
            i_term.set_run(1'b1);
            n = 0;
            while (act !== 1'b0 && n < 12) begin
                @(negedge clk_i);
                n++;
            end
            chk(16'(act), 16'h0000);
        end
        ramp(16'h0258, 10);
        i_term.set_run(1'b0);
        ramp(16'h0000, 10);
        $display("fast stop test done");
    endtask : t_fstop

    task automatic t_reject();
        cfg(5'h09, 16'h0001, 1'b0);
        cfg(5'h00, 16'h1771, 1'b0);
        cfg(5'h09, 16'h0000, 1'b1);
        cfg(5'h00, 16'h1770, 1'b0);
        cfg(5'h09, 16'h0000, 1'b0);
        cfg(5'h00, 16'hea61, 1'b1);
        cfg(5'h0a, 16'h0fa1, 1'b1);
        cfg(5'h0a, 16'h0fa0, 1'b0);
        cfg(5'h0f, 16'h03e9, 1'b1);
        cfg(5'h0f, 16'h03e8, 1'b0);
        $display("setting check test done");
    endtask : t_reject

    initial begin
        sys_rst  = 1'b1;
        cfg_wr   = 1'b0;
        cfg_sel  = 5'h00;
        cfg_data = 16'h0000;
        fault    = 1'b0;
        tune     = 1'b0;
        target   = 16'h0000;
        repeat (20) @(negedge clk_i);
        sys_rst = 1'b0;
        t_accel();
        t_sets();
        t_fstop();
        t_reject();
        results();
    end
endmodule : frg_ramp_tb

bind frg_ramp frg_ramp_asserts i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cfg_wr_i(cfg_wr_i), .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i),
    .cfg_reject_o(cfg_reject_o), .fault_stop_i(fault_stop_i),
    .target_freq_i(target_freq_i), .freq_o(freq_o),
    .fast_stop_active_o(fast_stop_active_o));

// ===== sim/frg_terminals.sv
// Model of the drive input terminals facing the ramp generator.
`timescale 1ns/1ps
module frg_terminals (
    // Clock
    input  wire logic       clk_i,
    // Terminal levels
    output logic            run_o,
    output logic            fs_no_o,
    output logic            fs_nc_n_o,
    output logic [1:0]      sel_o
);
    initial begin
        run_o     = 1'b0;
        fs_no_o   = 1'b0;
        fs_nc_n_o = 1'b1;
        sel_o     = 2'h0;
    end

    task automatic set_run(input logic v);
        @(negedge clk_i);
        run_o = v;
    endtask : set_run

    task automatic set_sel(input logic [1:0] v);
        @(negedge clk_i);
        sel_o = v;
    endtask : set_sel

    task automatic pulse(input logic nc);
        @(negedge clk_i);
        fs_no_o   = !nc;
        fs_nc_n_o = !nc;
        repeat (6) @(negedge clk_i);
        fs_no_o   = 1'b0;
        fs_nc_n_o = 1'b1;
    endtask : pulse
endmodule : frg_terminals
